// >>> logic/mcuxt_exec.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mcuxt_exec
   import mcuxt_pkg::*;
#(
   parameter int PM_AW = 11,
   parameter int PM_DW = 16
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // Instruction issue
   input  wire logic               op_valid,
   input  wire mcuxt_req_t         op_req,
   output logic                    op_ready,
   // Program counter side
   input  wire logic [PM_AW-9:0]   pc_page,
   output logic                    skip,
   // Data memory write port
   output logic                    mem_we,
   output logic [7:0]              mem_waddr,
   output logic [7:0]              mem_wdata,
   // Program memory read port
   output logic                    pm_rd,
   output logic [PM_AW-1:0]        pm_addr,
   input  wire logic [PM_DW-1:0]   pm_data,
   // Register port
   input  wire logic [2:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic [7:0]              reg_rdata,
   // Core state
   output logic [7:0]              acc,
   output mcuxt_flags_t            flags
);

   localparam int PH = PM_AW - 8;
   localparam int LH = PM_DW - 8;

   typedef struct packed {
      mcuxt_state_t   st;
      logic [7:0]     acc;
      mcuxt_flags_t   fl;
      logic [PH-1:0]  table_pointer_high;
      logic [7:0]     table_pointer_low;
      logic [LH-1:0]  table_latch_high;
      logic [7:0]     tab_dst;
      logic           skip;
      logic           mem_we;
      logic [7:0]     mem_waddr;
      logic [7:0]     mem_wdata;
      logic           pm_rd;
      logic [PM_AW-1:0] pm_addr;
      logic [7:0]     rdata;
   } mcuxt_s_t;

   mcuxt_s_t s;
   mcuxt_s_t next_s;

   logic       take;
   logic [7:0] a;
   logic [7:0] m;
   logic [7:0] b;
   logic       cin;
   logic [8:0] dsum;
   logic [4:0] nsum;
   logic [7:0] diff;
   logic [7:0] dec;
   logic [7:0] inc;
   logic [7:0] mask;
   logic [7:0] swp;
   logic [7:0] xr;
   logic       bit_val;

   assign op_ready = (s.st == ST_IDLE);
   assign take     = op_valid & op_ready;
   assign a        = s.acc;
   assign m        = op_req.operand;
   assign mask     = BYTE_ONE << op_req.bit_sel;
   assign bit_val  = |(m & mask);
   assign dec      = m - BYTE_ONE;
   assign inc      = m + BYTE_ONE;
   assign swp      = {m[3:0], m[7:4]};
   assign b        = (op_req.op == OP_SBC_IMM || op_req.op == OP_SUB_IMM)
                     ? op_req.imm : m;
   assign xr       = a ^ ((op_req.op == OP_XOR_IMM) ? op_req.imm : m);

   // Borrow subtract as add of complement; carry out one means no borrow
   always_comb begin
      cin  = 1'b1;
      if (op_req.op == OP_SBC_ACC || op_req.op == OP_SBC_MEM ||
          op_req.op == OP_SBC_IMM) begin
         cin = s.fl.c;
      end
      dsum = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
      nsum = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      diff = dsum[7:0];
   end

   always_comb begin
      next_s        = s;
      next_s.skip   = 1'b0;
      next_s.mem_we = 1'b0;
      next_s.pm_rd  = 1'b0;
      next_s.rdata  = BYTE_ZERO;
      // Register writes first so a same-cycle instruction result wins
      if (reg_wr) begin
         unique case (reg_addr)
            REG_ACC:   next_s.acc  = reg_wdata;
            REG_FLAGS: next_s.fl   = reg_wdata[3:0];
            REG_TABLE_POINTER_LOW:  next_s.table_pointer_low = reg_wdata;
            REG_TABLE_POINTER_HIGH:  next_s.table_pointer_high = reg_wdata[PH-1:0];
            default:   next_s.acc  = s.acc;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            REG_ACC:   next_s.rdata = s.acc;
            REG_FLAGS: next_s.rdata = {4'h0, s.fl};
            REG_TABLE_POINTER_LOW:  next_s.rdata = s.table_pointer_low;
            REG_TABLE_POINTER_HIGH:  next_s.rdata = 8'(s.table_pointer_high);
            REG_TABLE_LATCH_HIGH:  next_s.rdata = 8'(s.table_latch_high);
            default:   next_s.rdata = BYTE_ZERO;
         endcase
      end
      unique case (s.st)
         ST_IDLE: begin
            if (take) begin
               next_s.mem_waddr = op_req.addr;
               unique case (op_req.op)
                  OP_SBC_ACC, OP_SBC_IMM, OP_SUB_ACC, OP_SUB_IMM,
                  OP_SBC_MEM, OP_SUB_MEM: begin
                     next_s.fl.c  = dsum[8];
                     next_s.fl.ac = nsum[4];
                     next_s.fl.z  = (diff == BYTE_ZERO);
                     next_s.fl.ov = (a[7] ^ b[7]) & (diff[7] ^ a[7]);
                     if (op_req.op == OP_SBC_MEM ||
                         op_req.op == OP_SUB_MEM) begin
                        next_s.mem_we    = 1'b1;
                        next_s.mem_wdata = diff;
                     end else begin
                        next_s.acc = diff;
                     end
                  end
                  OP_DEC_SKIP: begin
                     next_s.mem_we    = 1'b1;
                     next_s.mem_wdata = dec;
                     next_s.skip      = (dec == BYTE_ZERO);
                  end
                  OP_DEC_ACC: begin
                     next_s.acc  = dec;
                     next_s.skip = (dec == BYTE_ZERO);
                  end
                  OP_INC_SKIP: begin
                     next_s.mem_we    = 1'b1;
                     next_s.mem_wdata = inc;
                     next_s.skip      = (inc == BYTE_ZERO);
                  end
                  OP_INC_ACC: begin
                     next_s.acc  = inc;
                     next_s.skip = (inc == BYTE_ZERO);
                  end
                  OP_SET_BYTE: begin
                     next_s.mem_we    = 1'b1;
                     next_s.mem_wdata = BYTE_ONES;
                  end
                  OP_SET_BIT: begin
                     next_s.mem_we    = 1'b1;
                     next_s.mem_wdata = m | mask;
                  end
                  OP_BIT_SET_SK: next_s.skip = bit_val;
                  OP_BIT_CLR_SK: next_s.skip = ~bit_val;
                  OP_ZERO_SKIP:  next_s.skip = (m == BYTE_ZERO);
                  OP_COPY_SKIP: begin
                     next_s.acc  = m;
                     next_s.skip = (m == BYTE_ZERO);
                  end
                  OP_SWAP_MEM: begin
                     next_s.mem_we    = 1'b1;
                     next_s.mem_wdata = swp;
                  end
                  OP_SWAP_ACC: next_s.acc = swp;
                  OP_TAB_PAGED, OP_TAB_CUR, OP_TAB_LAST: begin
                     next_s.st      = ST_TAB_REQ;
                     next_s.pm_rd   = 1'b1;
                     next_s.tab_dst = op_req.addr;
                     if (op_req.op == OP_TAB_PAGED) begin
                        next_s.pm_addr = {s.table_pointer_high, s.table_pointer_low};
                     end else if (op_req.op == OP_TAB_CUR) begin
                        next_s.pm_addr = {pc_page, s.table_pointer_low};
                     end else begin
                        next_s.pm_addr = {{PH{1'b1}}, s.table_pointer_low};
                     end
                  end
                  OP_XOR_ACC, OP_XOR_IMM, OP_XOR_MEM: begin
                     next_s.fl.z = (xr == BYTE_ZERO);
                     if (op_req.op == OP_XOR_MEM) begin
                        next_s.mem_we    = 1'b1;
                        next_s.mem_wdata = xr;
                     end else begin
                        next_s.acc = xr;
                     end
                  end
                  default: next_s.st = ST_IDLE;
               endcase
               if (next_s.skip) begin
                  next_s.st = ST_DUMMY;
               end
            end
         end
         // Slot of the discarded instruction; nothing is accepted
         ST_DUMMY: next_s.st = ST_IDLE;
         ST_TAB_REQ: next_s.st = ST_TAB_CAP;
         ST_TAB_CAP: begin
            next_s.st        = ST_IDLE;
            next_s.mem_we    = 1'b1;
            next_s.mem_waddr = s.tab_dst;
            next_s.mem_wdata = pm_data[7:0];
            next_s.table_latch_high      = pm_data[PM_DW-1:8];
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s       <= '0;
         s.st    <= ST_IDLE;
         s.acc   <= ACC_RESET;
         s.fl    <= FLAGS_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign skip      = s.skip;
   assign mem_we    = s.mem_we;
   assign mem_waddr = s.mem_waddr;
   assign mem_wdata = s.mem_wdata;
   assign pm_rd     = s.pm_rd;
   assign pm_addr   = s.pm_addr;
   assign reg_rdata = s.rdata;
   assign acc       = s.acc;
   assign flags     = s.fl;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic op_sbc_acc;
   logic op_sub_acc;
   logic op_sbc_mem;
   logic op_dec_sk;
   logic op_deca;
   logic op_set_b;
   logic op_inc_sk;
   logic op_swap;
   logic op_tab;
   logic op_xor;
   logic op_bset;
   assign op_sbc_acc = take && op_req.op == OP_SBC_ACC;
   assign op_sub_acc = take && op_req.op == OP_SUB_ACC;
   assign op_sbc_mem = take && op_req.op == OP_SBC_MEM;
   assign op_dec_sk  = take && op_req.op == OP_DEC_SKIP;
   assign op_deca    = take && op_req.op == OP_DEC_ACC;
   assign op_set_b   = take && op_req.op == OP_SET_BIT;
   assign op_inc_sk  = take && op_req.op == OP_INC_SKIP;
   assign op_swap    = take && op_req.op == OP_SWAP_MEM;
   assign op_tab     = take && op_req.op == OP_TAB_PAGED;
   assign op_xor     = take && op_req.op == OP_XOR_ACC;
   assign op_bset    = take && op_req.op == OP_BIT_SET_SK;

   sequence tab_fetch;
      pm_rd && pm_addr == $past({s.table_pointer_high, s.table_pointer_low}) ##1 !pm_rd;
   endsequence
   sequence tab_store;
      mem_we && mem_wdata == $past(pm_data[7:0]);
   endsequence

   a_sbc_acc_calc: assert property (op_sbc_acc |=>
      acc == 8'($past(a) - $past(m) - 8'(!$past(s.fl.c))))
      else $error("borrow subtract result wrong");
   a_sub_carry: assert property (op_sub_acc |=>
      flags.c == ($past(a) >= $past(m)) && acc == 8'($past(a) - $past(m)))
      else $error("subtract carry wrong");
   a_sbc_mem_wr: assert property (op_sbc_mem |=> mem_we &&
      mem_wdata == 8'($past(a) - $past(m) - 8'(!$past(s.fl.c))) && $stable(acc))
      else $error("borrow subtract to memory wrong");
   a_dec_skip: assert property (op_dec_sk |=>
      mem_wdata == 8'($past(m) - 8'h01) && skip == ($past(m) == 8'h01))
      else $error("decrement skip wrong");
   a_deca_flags: assert property (op_deca |=>
      $stable(flags) && !mem_we && acc == 8'($past(m) - 8'h01))
      else $error("decrement to acc wrong");
   a_skip_dummy: assert property (skip |-> !op_ready ##1 op_ready)
      else $error("skip without dummy slot");
   a_set_bit: assert property (op_set_b |=> mem_we &&
      mem_wdata == ($past(m) | $past(mask)) && $stable(flags))
      else $error("set bit wrong");
   a_inc_skip: assert property (op_inc_sk |=>
      mem_wdata == 8'($past(m) + 8'h01) && skip == ($past(m) == 8'hFF))
      else $error("increment skip wrong");
   a_bit_skip: assert property (op_bset |=> skip == $past(bit_val))
      else $error("bit set skip wrong");
   a_swap_mem: assert property (op_swap |=>
      mem_wdata == {$past(m[3:0]), $past(m[7:4])} && $stable(flags))
      else $error("nibble swap wrong");
   a_tab_read: assert property (op_tab |=> tab_fetch ##1 tab_store)
      else $error("table read sequence wrong");
   a_xor_flags: assert property (op_xor |=>
      $stable(flags.c) && $stable(flags.ov) && flags.z == (acc == 8'h00))
      else $error("xor flag update wrong");

endmodule : mcuxt_exec
`default_nettype wire

// >>> logic/mcuxt_pkg.sv
// Summary of operation
// - Borrow subtract to acc: acc minus operand minus inverted carry; carry clear if negative.
// - Borrow subtract to memory: same arithmetic and carry, result written to memory byte.
// - All subtract forms update overflow, zero, nibble carry and carry flags.
// - Decrement memory byte, store back, skip next instruction when result is zero.
// - Memory minus one into acc, memory and flags untouched, skip on zero.
// - A taken skip inserts one dummy slot, the skipping instruction takes two cycles.
// - Set byte writes all ones to memory, flags unchanged.
// - Set bit forces the selected memory bit to one, flags unchanged.
// - Increment memory byte, store back, no flag change, skip on zero.
// - Memory plus one into acc, memory unchanged, skip on zero.
// - Skip next instruction when selected memory bit is one, no flag change.
// - Plain subtract to acc, carry clear on negative, set otherwise.
// - Plain subtract with result written to memory, same carry convention.
// - Immediate subtract into acc, same carry convention.
// - Swap memory nibbles in place, no flag change.
// - Swapped memory byte into acc, memory and flags untouched.
// - Skip next instruction when memory byte is zero, no flag change.
// - Copy memory byte to acc, skip when zero, no flag change.
// - Skip next instruction when selected memory bit is zero, no flag change.
// - Paged table read: both pointers address word, low byte to memory, high to latch.
// - Current and last page reads use low pointer with program or last page.
// - Exclusive-or of acc with memory or immediate, only zero flag updated.
package mcuxt_pkg;

   typedef enum logic [4:0] {
      OP_NOP        = 5'h00,
      OP_SBC_ACC    = 5'h01,
      OP_SBC_MEM    = 5'h02,
      OP_SBC_IMM    = 5'h03,
      OP_SUB_ACC    = 5'h04,
      OP_SUB_MEM    = 5'h05,
      OP_SUB_IMM    = 5'h06,
      OP_DEC_SKIP   = 5'h07,
      OP_DEC_ACC    = 5'h08,
      OP_INC_SKIP   = 5'h09,
      OP_INC_ACC    = 5'h0A,
      OP_SET_BYTE   = 5'h0B,
      OP_SET_BIT    = 5'h0C,
      OP_BIT_SET_SK = 5'h0D,
      OP_BIT_CLR_SK = 5'h0E,
      OP_ZERO_SKIP  = 5'h0F,
      OP_COPY_SKIP  = 5'h10,
      OP_SWAP_MEM   = 5'h11,
      OP_SWAP_ACC   = 5'h12,
      OP_TAB_PAGED  = 5'h13,
      OP_TAB_CUR    = 5'h14,
      OP_TAB_LAST   = 5'h15,
      OP_XOR_ACC    = 5'h16,
      OP_XOR_MEM    = 5'h17,
      OP_XOR_IMM    = 5'h18
   } mcuxt_op_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_DUMMY   = 2'b01,
      ST_TAB_REQ = 2'b10,
      ST_TAB_CAP = 2'b11
   } mcuxt_state_t;

   typedef struct packed {
      logic ov;
      logic z;
      logic ac;
      logic c;
   } mcuxt_flags_t;

   typedef struct packed {
      mcuxt_op_t  op;
      logic [7:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] imm;
      logic [7:0] operand;
   } mcuxt_req_t;

   localparam logic [2:0] REG_ACC   = 3'h0;
   localparam logic [2:0] REG_FLAGS = 3'h1;
   localparam logic [2:0] REG_TABLE_POINTER_LOW  = 3'h2;
   localparam logic [2:0] REG_TABLE_POINTER_HIGH  = 3'h3;
   localparam logic [2:0] REG_TABLE_LATCH_HIGH  = 3'h4;

   localparam logic [7:0] ACC_RESET   = 8'h00;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [7:0] BYTE_ONES   = 8'hFF;
   localparam logic [7:0] BYTE_ONE    = 8'h01;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;

endpackage : mcuxt_pkg

// >>> test/mcuxt_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcuxt_exec_tb
   import mcuxt_pkg::*;
;
   // Clock and reset
   logic         clk;
   logic         rst;
   // Design ports
   logic         op_valid;
   mcuxt_req_t   op_req;
   logic         op_ready;
   logic [2:0]   pc_page;
   logic         skip;
   logic         mem_we;
   logic [7:0]   mem_waddr;
   logic [7:0]   mem_wdata;
   logic         pm_rd;
   logic [10:0]  pm_addr;
   logic [15:0]  pm_data;
   logic [2:0]   reg_addr;
   logic [7:0]   reg_wdata;
   logic         reg_wr;
   logic         reg_rd;
   logic [7:0]   reg_rdata;
   logic [7:0]   acc;
   mcuxt_flags_t flags;
   // Bench state
   int           err_count;
   int           num_checks;
   logic [7:0]   ca [6] = '{8'h00, 8'h80, 8'h10, 8'h7F, 8'h3C, 8'h01};
   logic [7:0]   cb [6] = '{8'h01, 8'h01, 8'h10, 8'hFF, 8'h00, 8'h80};
   logic [3:0]   cf [6] = '{4'h0, 4'hF, 4'h1, 4'hE, 4'h5, 4'h2};

   mcuxt_exec dut_u (
      .clk       (clk),
      .rst       (rst),
      .op_valid  (op_valid),
      .op_req    (op_req),
      .op_ready  (op_ready),
      .pc_page   (pc_page),
      .skip      (skip),
      .mem_we    (mem_we),
      .mem_waddr (mem_waddr),
      .mem_wdata (mem_wdata),
      .pm_rd     (pm_rd),
      .pm_addr   (pm_addr),
      .pm_data   (pm_data),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .acc       (acc),
      .flags     (flags)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Program word depends on every address bit so a wrong page shows
   function automatic logic [15:0] tw(logic [10:0] a);
      return {5'h0A, a[10:8], a[7:0] ^ 8'hC3};
   endfunction

   // Word valid only in the cycle after the read pulse, junk otherwise
   always @(posedge clk) begin
      pm_data <= pm_rd ? tw(pm_addr) : ~pm_data;
   end

   // Returns {skip, mem write, value, acc, flags}
   function automatic logic [21:0] model(mcuxt_op_t o, logic [7:0] a,
         logic [7:0] b, logic [7:0] im, logic [3:0] f);
      logic [7:0] y;
      logic [7:0] v;
      logic [8:0] s;
      logic [4:0] n;
      logic       cin;
      logic       sk;
      logic       we;
      logic       na;
      logic [3:0] fl;
      y   = (o inside {OP_SBC_IMM, OP_SUB_IMM, OP_XOR_IMM}) ? im : b;
      cin = (o inside {OP_SBC_ACC, OP_SBC_MEM, OP_SBC_IMM}) ? f[0] : 1'b1;
      s   = {1'b0, a} + {1'b0, ~y} + {8'h00, cin};
      n   = {1'b0, a[3:0]} + {1'b0, ~y[3:0]} + {4'h0, cin};
      fl  = f;
      case (o)
         OP_DEC_SKIP, OP_DEC_ACC: v = b - 8'h01;
         OP_INC_SKIP, OP_INC_ACC: v = b + 8'h01;
         OP_SET_BYTE:             v = 8'hFF;
         OP_SET_BIT:              v = b | 8'h80;
         OP_SWAP_MEM, OP_SWAP_ACC: v = {b[3:0], b[7:4]};
         OP_XOR_ACC, OP_XOR_MEM, OP_XOR_IMM: v = a ^ y;
         default:                 v = (o <= OP_SUB_IMM) ? s[7:0] : b;
      endcase
      if (o >= OP_SBC_ACC && o <= OP_SUB_IMM) begin
         fl = {(a[7] != y[7]) && (v[7] != a[7]), v == 8'h00, n[4], s[8]};
      end
      if (o inside {OP_XOR_ACC, OP_XOR_MEM, OP_XOR_IMM}) begin
         fl[2] = (v == 8'h00);
      end
      we = o inside {OP_SBC_MEM, OP_SUB_MEM, OP_DEC_SKIP, OP_INC_SKIP,
                     OP_SET_BYTE, OP_SET_BIT, OP_SWAP_MEM, OP_XOR_MEM};
      na = o inside {OP_SBC_ACC, OP_SBC_IMM, OP_SUB_ACC, OP_SUB_IMM,
                     OP_DEC_ACC, OP_INC_ACC, OP_COPY_SKIP, OP_SWAP_ACC,
                     OP_XOR_ACC, OP_XOR_IMM};
      sk = (o inside {[OP_DEC_SKIP:OP_INC_ACC], OP_ZERO_SKIP, OP_COPY_SKIP}
            && v == 8'h00) || (o == OP_BIT_SET_SK && b[7])
            || (o == OP_BIT_CLR_SK && !b[7]);
      return {sk, we, v, na ? v : a, fl};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
         input string m);
      num_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
         err_count++;
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Returns settled in the cycle after the take
   task automatic issue(input mcuxt_op_t o, input logic [7:0] a,
         input logic [7:0] b, input logic [7:0] im);
      int k;
      k = 0;
      while (op_ready !== 1'b1) begin
         @(posedge clk);
         #1;
         k++;
         if (k > 8) begin
            err_count++;
            summarize();
         end
      end
      @(posedge clk);
      op_valid <= 1'b1;
      op_req   <= '{op: o, addr: a, bit_sel: 3'h7, imm: im, operand: b};
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
   endtask

   initial begin
      logic [21:0] e;
      logic [7:0]  d;
      logic [10:0] pa;
      logic [15:0] tv;
      err_count = 0;
      num_checks = 0;
      rst = 1'b1;
      op_valid = 1'b0;
      op_req = '0;
      pc_page = 3'h2;
      pm_data = 16'h0000;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(16'({acc, flags, op_ready, skip, mem_we, pm_rd}), 16'h0008, "rst");
      reg_read(REG_TABLE_LATCH_HIGH, d);
      chk(16'(d), 16'h0000, "table_latch_high rst");
      // Register port: read back, read-only latch, unmapped index
      reg_write(REG_ACC, 8'h96);
      reg_read(REG_ACC, d);
      chk(16'(d), 16'h0096, "acc rw");
      @(posedge clk);
      #1;
      chk(16'(reg_rdata), 16'h0000, "rdata idle");
      reg_write(REG_TABLE_LATCH_HIGH, 8'h5C);
      reg_read(REG_TABLE_LATCH_HIGH, d);
      chk(16'(d), 16'h0000, "table_latch_high ro");
      reg_read(3'h7, d);
      chk(16'(d), 16'h0000, "unmapped");
      // Every non-table operation except NOP over each operand case
      for (int i = 0; i < 6; i++) begin
         for (int o = 1; o <= 24; o++) begin
            if (o < 19 || o > 21) begin
               reg_write(REG_ACC, ca[i]);
               reg_write(REG_FLAGS, {4'h0, cf[i]});
               e = model(mcuxt_op_t'(o), ca[i], cb[i], cb[i] ^ 8'h5A, cf[i]);
               issue(mcuxt_op_t'(o), 8'(8'h40 + o), cb[i], cb[i] ^ 8'h5A);
               chk(16'(skip), 16'(e[21]), "skip");
               chk(16'(op_ready), 16'(!e[21]), "dummy slot");
               chk(16'(mem_we), 16'(e[20]), "mem we");
               if (e[20]) begin
                  chk({mem_waddr, mem_wdata}, {8'(8'h40 + o), e[19:12]},
                      "mem");
               end
               chk(16'(acc), 16'(e[11:4]), "acc");
               chk(16'(flags), 16'(e[3:0]), "flags");
            end
         end
      end
      // Table reads: paged, current page, last page
      reg_write(REG_TABLE_POINTER_LOW, 8'hA5);
      reg_write(REG_TABLE_POINTER_HIGH, 8'hFD);
      reg_read(REG_TABLE_POINTER_HIGH, d);
      chk(16'(d), 16'h0005, "table_pointer_high");
      for (int t = 0; t < 3; t++) begin
         pa = (t == 0) ? 11'h5A5 : (t == 1) ? {pc_page, 8'hA5} : 11'h7A5;
         tv = tw(pa);
         issue(mcuxt_op_t'(19 + t), 8'h33, 8'h00, 8'h00);
         chk(16'({pm_rd, op_ready, pm_addr}), 16'({2'b10, pa}),
             "pm read");
         @(posedge clk);
         #1;
         chk(16'(op_ready), 16'h0000, "tab busy");
         @(posedge clk);
         #1;
         chk({mem_we, op_ready, 6'h00, mem_wdata}, {2'b11, 6'h00,
             tv[7:0]}, "tab low");
         chk(16'(mem_waddr), 16'h0033, "tab addr");
         reg_read(REG_TABLE_LATCH_HIGH, d);
         chk(16'(d), 16'(tv[15:8]), "tab high");
      end
      summarize();
   end
endmodule // mcuxt_exec_tb
`default_nettype wire
